// ### hdl/dac_output_clock_burst_sequencer.sv
// DAC output sequencer: sample clock, channel sequencing and triggered bursts
//
// What this block does
// - Sample clock rate is master clock divided by the programmed integer divisor.
// - Group mode: each sample clock loads a full active group, all outputs together.
// - Single mode: each sample clock moves exactly one value to its channel.
// - Single mode fills active channels lowest to highest, then wraps.
// - Single mode per-channel rate is clock rate over active channel count.
// - Burst off: every sample clock transfers while the buffer holds data.
// - Burst on: a trigger runs transfers until buffer empty or end-of-frame.
// - Internal source: software trigger or rate generator pulse starts a burst.
// - Software trigger bit reads high through its burst, clears at end.
// - Trigger initiator drives a short low pulse on the trigger pin per burst.
// - External source: trigger pin falling edge starts burst if enabled and idle.
// - Burst-idle flag is low during a burst, high otherwise.
// - Software trigger also starts bursts with external source selected.
// - After end-of-frame, no buffer values are taken until the next trigger.
// - A burst target runs exactly one burst per initiator burst.
// - Clock source bit low selects the clock pin, high the rate generator.
// - External clock acts on each falling edge of the clock pin.
// - Bit 16 of each buffered word marks the last value of a frame.
// - Divisor is a 24-bit read/write field with nonzero default, upper bits zero.
//
// Chosen here: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`include "dac_seq_defines.svh"
module dac_output_clock_burst_sequencer (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire dac_seq_pkg::buf_word_t buf_word,
  input wire logic buf_valid,
  output logic buf_ready,
  output dac_seq_pkg::dac_out_t dac_o,
  input wire logic clk_pin_i,
  output logic clk_pin_o,
  output logic clk_pin_oe_n,
  input wire logic trig_pin_i,
  output logic trig_pin_o,
  output logic trig_pin_oe_n
);

  function automatic logic [1:0] next_active(input logic [3:0] m, input logic [1:0] i);
    logic [1:0] r;
    logic [1:0] c;
    r = i;
    for (int k = 4; k >= 1; k--) begin
      c = i + 2'(k);
      if (m[c]) begin
        r = c;
      end
    end
    return r;
  endfunction

  function automatic logic [1:0] last_active(input logic [3:0] m);
    logic [1:0] r;
    r = 2'h0;
    for (int k = 0; k < 4; k++) begin
      if (m[k]) begin
        r = 2'(k);
      end
    end
    return r;
  endfunction

  logic [3:0] board_control_word_reg;
  logic [2:0] ops_reg;
  logic sw_trig_reg;
  logic sw_trig_next;
  logic sw_clk_reg;
  logic [3:0] mask_reg;
  logic [23:0] rate_c_reg;
  logic [23:0] rate_b_reg;
  logic [31:0] rd_mux;
  logic clk_s1, clk_s2, clk_s3;
  logic trig_s1, trig_s2, trig_s3;
  logic burst_active_reg;
  logic burst_active_next;
  dac_seq_pkg::seq_state_t state_reg;
  dac_seq_pkg::seq_state_t state_next;
  logic [1:0] ch_reg;
  logic [3:0][15:0] stage_reg;
  logic grp_eof_reg;
  logic [7:0] trig_cnt_reg;
  logic [7:0] trig_cnt_next;
  logic [7:0] clk_cnt_reg;
  logic [7:0] clk_cnt_next;
  logic [3:0][15:0] grp_vals;

  wire wr_ctrl = reg_wr && reg_addr == `OFS_BOARD_CTRL;
  wire wr_ops = reg_wr && reg_addr == `OFS_BUF_OPS;
  wire wr_mask = reg_wr && reg_addr == `OFS_CHAN_MASK;
  wire wr_rate_c = reg_wr && reg_addr == `OFS_RATE_C;
  wire wr_rate_b = reg_wr && reg_addr == `OFS_RATE_B;

  wire simul = board_control_word_reg[`BCW_SIMUL_BIT];
  wire trig_init = board_control_word_reg[`BCW_TRIG_INIT_BIT];
  wire clk_en = ops_reg[`OPS_CLK_EN_BIT];
  wire clk_init = ops_reg[`OPS_CLK_INIT_BIT];
  wire burst_en = ops_reg[`OPS_BURST_EN_BIT];
  wire burst_idle = !burst_active_reg;

  // Edge detectors read only the second and third flops of each synchroniser
  wire ext_clk_fall = clk_s3 && !clk_s2;
  wire trig_fall = trig_s3 && !trig_s2;

  wire rate_c_tick;
  wire rate_b_tick;

  rate_divider u_rate_c (
    .clk(clk),
    .rstn(rstn),
    .enable(board_control_word_reg[`BCW_RATE_C_EN_BIT]),
    .divisor(rate_c_reg),
    .tick(rate_c_tick)
  );

  rate_divider u_rate_b (
    .clk(clk),
    .rstn(rstn),
    .enable(board_control_word_reg[`BCW_RATE_B_EN_BIT]),
    .divisor(rate_b_reg),
    .tick(rate_b_tick)
  );

  // Software clock works even with clocking disabled
  wire sample_tick = sw_clk_reg || (clk_en && (clk_init ? rate_c_tick : ext_clk_fall));

  wire sw_trig_req = wr_ops && reg_wdata[`OPS_SW_TRIG_BIT];
  wire hw_trig_req = trig_init ? rate_b_tick : trig_fall;
  wire trig_req = sw_trig_req || hw_trig_req;
  // Triggers while a burst runs are dropped, so a target follows one for one
  wire burst_start = burst_en && burst_idle && trig_req;

  wire any_active = |mask_reg;
  wire may_move = burst_en ? burst_active_reg : 1'b1;
  wire [1:0] first_ch = next_active(mask_reg, 2'h3);
  wire [1:0] last_ch = last_active(mask_reg);
  wire [1:0] tgt_ch = mask_reg[ch_reg] ? ch_reg : next_active(mask_reg, ch_reg);
  wire idle_tick = state_reg == dac_seq_pkg::SEQ_IDLE && sample_tick && may_move && any_active;
  wire pop_seq = !simul && idle_tick && buf_valid;
  wire grp_start = simul && idle_tick && buf_valid;
  wire pop_grp = (grp_start || state_reg == dac_seq_pkg::SEQ_GATHER) && buf_valid;
  wire [1:0] cur_ch = grp_start ? first_ch : tgt_ch;
  wire grp_last = cur_ch == last_ch;
  wire grp_eof = buf_word.eof || grp_eof_reg;

  assign buf_ready = pop_seq || pop_grp;

  wire burst_end = burst_active_reg && ((pop_seq && buf_word.eof)
    || (pop_grp && grp_last && grp_eof)
    || (idle_tick && !buf_valid));

  always_comb begin
    for (int k = 0; k < 4; k++) begin
      grp_vals[k] = (2'(k) == cur_ch) ? buf_word.value : stage_reg[k];
    end
  end

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      dac_seq_pkg::SEQ_IDLE: begin
        if (grp_start && !grp_last) begin
          state_next = dac_seq_pkg::SEQ_GATHER;
        end
      end
      dac_seq_pkg::SEQ_GATHER: begin
        if (pop_grp && grp_last) begin
          state_next = dac_seq_pkg::SEQ_IDLE;
        end
      end
    endcase
  end

  assign burst_active_next = burst_start ? 1'b1 : (burst_end ? 1'b0 : burst_active_reg);
  assign sw_trig_next = (burst_start && sw_trig_req) ? 1'b1 : (burst_end ? 1'b0 : sw_trig_reg);

  assign trig_cnt_next = (burst_start && trig_init) ? 8'(`TRIG_PULSE_CYC)
    : (trig_cnt_reg != 8'h00 ? trig_cnt_reg - 8'h01 : 8'h00);
  assign clk_cnt_next = (sample_tick && clk_init) ? 8'(`CLK_PULSE_CYC)
    : (clk_cnt_reg != 8'h00 ? clk_cnt_reg - 8'h01 : 8'h00);

  always_comb begin
    rd_mux = 32'h00000000;
    unique case (reg_addr)
      `OFS_BOARD_CTRL: rd_mux[3:0] = board_control_word_reg;
      `OFS_BUF_OPS: rd_mux[4:0] = {1'b0, sw_trig_reg, ops_reg};
      `OFS_CHAN_MASK: rd_mux[3:0] = mask_reg;
      `OFS_STATUS: begin
        rd_mux[`STAT_IDLE_BIT] = burst_idle;
        rd_mux[`STAT_CLK_READY_BIT] = buf_valid;
        rd_mux[`STAT_BURST_BIT] = burst_active_reg;
      end
      `OFS_RATE_C: rd_mux[23:0] = rate_c_reg;
      `OFS_RATE_B: rd_mux[23:0] = rate_b_reg;
      default: rd_mux = 32'h00000000;
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      board_control_word_reg <= `BCW_RESET;
      ops_reg <= `OPS_RESET;
      mask_reg <= `MASK_RESET;
      rate_c_reg <= `RATE_C_RESET;
      rate_b_reg <= `RATE_B_RESET;
      sw_clk_reg <= 1'b0;
      reg_rdata <= 32'h00000000;
    end else begin
      if (wr_ctrl) board_control_word_reg <= reg_wdata[3:0];
      if (wr_ops) ops_reg <= reg_wdata[2:0];
      if (wr_mask) mask_reg <= reg_wdata[3:0];
      if (wr_rate_c) rate_c_reg <= reg_wdata[23:0];
      if (wr_rate_b) rate_b_reg <= reg_wdata[23:0];
      sw_clk_reg <= wr_ops && reg_wdata[`OPS_SW_CLK_BIT];
      reg_rdata <= reg_rd ? rd_mux : 32'h00000000;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      {clk_s1, clk_s2, clk_s3} <= 3'h7;
      {trig_s1, trig_s2, trig_s3} <= 3'h7;
    end else begin
      {clk_s1, clk_s2, clk_s3} <= {clk_pin_i, clk_s1, clk_s2};
      {trig_s1, trig_s2, trig_s3} <= {trig_pin_i, trig_s1, trig_s2};
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      burst_active_reg <= 1'b0;
      sw_trig_reg <= 1'b0;
      state_reg <= dac_seq_pkg::SEQ_IDLE;
      trig_cnt_reg <= 8'h00;
      clk_cnt_reg <= 8'h00;
      trig_pin_oe_n <= 1'b1;
      clk_pin_oe_n <= 1'b1;
    end else begin
      burst_active_reg <= burst_active_next;
      sw_trig_reg <= sw_trig_next;
      state_reg <= state_next;
      trig_cnt_reg <= trig_cnt_next;
      clk_cnt_reg <= clk_cnt_next;
      trig_pin_oe_n <= trig_cnt_next == 8'h00;
      clk_pin_oe_n <= clk_cnt_next == 8'h00;
    end
  end

  // Pins are only ever pulled low, so several boards can share the wire
  assign trig_pin_o = 1'b0;
  assign clk_pin_o = 1'b0;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ch_reg <= 2'h0;
      stage_reg <= '0;
      grp_eof_reg <= 1'b0;
      dac_o <= '0;
    end else begin
      dac_o.update <= 4'h0;
      if (pop_seq) begin
        dac_o.value[cur_ch] <= buf_word.value;
        dac_o.update <= 4'h1 << cur_ch;
        ch_reg <= next_active(mask_reg, cur_ch);
      end
      if (pop_grp) begin
        stage_reg[cur_ch] <= buf_word.value;
        grp_eof_reg <= grp_last ? 1'b0 : grp_eof;
        ch_reg <= next_active(mask_reg, cur_ch);
        if (grp_last) begin
          for (int k = 0; k < 4; k++) begin
            if (mask_reg[k]) dac_o.value[k] <= grp_vals[k];
          end
          dac_o.update <= mask_reg;
        end
      end
    end
  end

  idle_low_a: assert property (
    @(posedge clk) disable iff (!rstn)
    burst_active_reg && reg_rd && reg_addr == `OFS_STATUS
    |=> !reg_rdata[`STAT_IDLE_BIT] && reg_rdata[`STAT_BURST_BIT])
    else $error("burst idle flag high after burst start");

  single_pop_a: assert property (
    @(posedge clk) disable iff (!rstn)
    pop_seq |=> $countones(dac_o.update) == 1)
    else $error("single mode did not update exactly one channel");

  group_all_a: assert property (
    @(posedge clk) disable iff (!rstn)
    pop_grp && grp_last && $stable(mask_reg) |=> dac_o.update == mask_reg)
    else $error("group update missed active channels");

  ext_trig_a: assert property (
    @(posedge clk) disable iff (!rstn)
    !trig_init && trig_fall && burst_en && burst_idle |=> burst_active_reg)
    else $error("external trigger edge did not start a burst");

  no_pop_idle_a: assert property (
    @(posedge clk) disable iff (!rstn)
    burst_en && burst_idle |-> !buf_ready)
    else $error("buffer read while burst mode idle");

  trig_pulse_a: assert property (
    @(posedge clk) disable iff (!rstn)
    burst_start && trig_init |=> !trig_pin_oe_n [*8])
    else $error("trigger pin pulse too short");

  sw_bit_clear_a: assert property (
    @(posedge clk) disable iff (!rstn)
    burst_end |=> !sw_trig_reg && burst_idle)
    else $error("software trigger bit did not clear at burst end");

  eof_stop_a: assert property (
    @(posedge clk) disable iff (!rstn)
    burst_en && pop_seq && buf_word.eof |=> burst_idle ##1 !buf_ready)
    else $error("burst ran past end of frame");

  cont_move_a: assert property (
    @(posedge clk) disable iff (!rstn)
    !burst_en && !simul && sample_tick && any_active && buf_valid |-> buf_ready)
    else $error("continuous mode skipped a transfer");

  ascend_a: assert property (
    @(posedge clk) disable iff (!rstn)
    pop_seq && mask_reg[cur_ch + 2'h1] |=> ch_reg == $past(cur_ch) + 2'h1)
    else $error("channel order broken");

endmodule // dac_output_clock_burst_sequencer

// ### hdl/dac_seq_defines.svh
// Register offsets, field positions, reset values and timing counts of the DAC sequencer
`ifndef DAC_SEQ_DEFINES_SVH
`define DAC_SEQ_DEFINES_SVH

`define OFS_BOARD_CTRL 8'h00
`define OFS_BUF_OPS 8'h04
`define OFS_CHAN_MASK 8'h08
`define OFS_STATUS 8'h0C
`define OFS_RATE_C 8'h4C
`define OFS_RATE_B 8'h50

`define BCW_SIMUL_BIT 0
`define BCW_TRIG_INIT_BIT 1
`define BCW_RATE_C_EN_BIT 2
`define BCW_RATE_B_EN_BIT 3

`define OPS_CLK_EN_BIT 0
`define OPS_CLK_INIT_BIT 1
`define OPS_BURST_EN_BIT 2
`define OPS_SW_TRIG_BIT 3
`define OPS_SW_CLK_BIT 4

`define STAT_IDLE_BIT 0
`define STAT_CLK_READY_BIT 1
`define STAT_BURST_BIT 2

`define BCW_RESET 4'h0
`define OPS_RESET 3'h0
`define MASK_RESET 4'hF
`define RATE_C_RESET 24'h00007E
`define RATE_B_RESET 24'h001000

`define CLK_MHZ 200
`define TRIG_PULSE_NS 100
`define TRIG_PULSE_CYC ((`TRIG_PULSE_NS * `CLK_MHZ + 999) / 1000)
`define CLK_PULSE_NS 20
`define CLK_PULSE_CYC ((`CLK_PULSE_NS * `CLK_MHZ + 999) / 1000)

`endif

// ### hdl/dac_seq_pkg.sv
// Types shared by the DAC sequencer files
package dac_seq_pkg;

  typedef struct packed {
    logic eof;
    logic [15:0] value;
  } buf_word_t;

  typedef struct packed {
    logic [3:0] update;
    logic [3:0][15:0] value;
  } dac_out_t;

  typedef enum logic [0:0] {
    SEQ_IDLE,
    SEQ_GATHER
  } seq_state_t;

endpackage

// ### hdl/rate_divider.sv
// Integer divider producing one tick per divisor cycles of the master clock
`timescale 1ns/1ps
module rate_divider (
  input wire logic clk,
  input wire logic rstn,
  input wire logic enable,
  input wire logic [23:0] divisor,
  output logic tick
);

  logic [23:0] count_reg;
  logic [23:0] count_next;
  logic wrap;

  // Divisor 0 or 1 ticks every cycle
  assign wrap = (count_reg + 24'h000001) >= divisor;
  assign count_next = (!enable || wrap) ? 24'h000000 : count_reg + 24'h000001;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      count_reg <= 24'h000000;
      tick <= 1'b0;
    end else begin
      count_reg <= count_next;
      tick <= enable && wrap;
    end
  end

  rate_gap_a: assert property (
    @(posedge clk) disable iff (!rstn)
    tick && divisor >= 24'h000002 && $stable(divisor) |=> !tick)
    else $error("rate divider ticked twice in a row");

endmodule // rate_divider

// ### bench/buf_source.sv
// Output buffer stand-in: a queue of words presented head first
`timescale 1ns/1ps
module buf_source (
  input wire logic clk,
  input wire logic rstn,
  input wire logic load,
  input wire dac_seq_pkg::buf_word_t load_word,
  output dac_seq_pkg::buf_word_t buf_word,
  output logic buf_valid,
  input wire logic buf_ready
);
  dac_seq_pkg::buf_word_t q[$];
  dac_seq_pkg::buf_word_t last;
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      q.delete();
      last = '0;
    end else begin
      if (buf_valid && buf_ready) begin
        last = q.pop_front();
      end
      if (load) begin
        q.push_back(load_word);
      end
    end
    buf_valid <= (q.size() != 0);
    // Empty buffer shows the inverse of the last popped word so a stray pop cannot look like real data
    buf_word <= (q.size() != 0) ? q[0] : ~last;
  end
endmodule // buf_source

// ### bench/tb_dac_output_clock_burst_sequencer.sv
// Register-driven tests of the DAC output sequencer
`timescale 1ns/1ps
module tb_dac_output_clock_burst_sequencer;
  logic clk, rstn, reg_wr, reg_rd, buf_valid, buf_ready, load;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  dac_seq_pkg::buf_word_t buf_word, load_word;
  dac_seq_pkg::dac_out_t dac_o;
  logic clk_pin_o, clk_pin_oe_n, trig_pin_o, trig_pin_oe_n, clk_drv, trig_drv;
  // One board alone on the shared pins, inside the group size limit
  wire logic clk_w = clk_pin_oe_n ? clk_drv : clk_pin_o;
  wire logic trig_w = trig_pin_oe_n ? trig_drv : trig_pin_o;
  int bad_count = 0;
  int total_checks = 0;
  int cyc = 0;
  logic trig_low_seen;
  dac_seq_pkg::dac_out_t upd_q[$];
  int stamp_q[$];
  // Sample clock divisor: 1 MSPS from the 200 MHz master clock, under the rate limit
  localparam int DIV = 200;

  dac_output_clock_burst_sequencer dut (.clk(clk), .rstn(rstn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .buf_word(buf_word), .buf_valid(buf_valid), .buf_ready(buf_ready), .dac_o(dac_o),
    .clk_pin_i(clk_w), .clk_pin_o(clk_pin_o), .clk_pin_oe_n(clk_pin_oe_n),
    .trig_pin_i(trig_w), .trig_pin_o(trig_pin_o), .trig_pin_oe_n(trig_pin_oe_n));
  buf_source src (.clk(clk), .rstn(rstn), .load(load), .load_word(load_word),
    .buf_word(buf_word), .buf_valid(buf_valid), .buf_ready(buf_ready));

  always #2.5 clk = ~clk;

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (dac_o.update !== 4'h0) begin
      upd_q.push_back(dac_o);
      stamp_q.push_back(cyc);
    end
    if (trig_pin_oe_n === 1'b0) begin
      trig_low_seen = 1'b1;
    end
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    check("register read", reg_rdata, exp);
  endtask

  task automatic push(input logic [15:0] v, input logic eof);
    @(posedge clk);
    load <= 1'b1;
    load_word <= {eof, v};
    @(posedge clk);
    load <= 1'b0;
  endtask

  // Checks that update i hit only channel ch with value v
  task automatic upd_is(input int i, input int ch, input logic [31:0] v);
    check("update mask", upd_q[i].update, 4'h1 << ch);
    check("channel value", upd_q[i].value[ch], v);
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
  endtask

  initial begin
    #30000;
    bad_count++;
    close_out();
  end

  initial begin
    clk = 0; rstn = 0; reg_wr = 0; reg_rd = 0; reg_addr = 8'h00; reg_wdata = 32'h0;
    load = 0; load_word = '0; clk_drv = 1; trig_drv = 1; trig_low_seen = 0;
    settle(12);
    rstn <= 1'b1;
    rd(8'h4C, 32'h0000007E);
    rd(8'h08, 32'h0000000F);
    rd(8'h0C, 32'h00000001);
    rd(8'h20, 32'h00000000);
    wr(8'h4C, 32'hFFFFFFFF);
    rd(8'h4C, 32'h00FFFFFF);
    // Divisor is set once, before clocking starts
    wr(8'h4C, DIV);
    // Single mode over channels 1 and 2; data queued before clocking starts
    wr(8'h08, 32'h00000006);
    for (int i = 0; i < 4; i++) push(16'(16'hA000 + i), 1'b0);
    upd_q.delete();
    stamp_q.delete();
    wr(8'h00, 32'h00000004);
    wr(8'h04, 32'h00000003);
    settle(4 * DIV + 20);
    check("single count", upd_q.size(), 4);
    for (int i = 0; i < upd_q.size(); i++) upd_is(i, 1 + i % 2, 32'hA000 + i);
    for (int i = 1; i < stamp_q.size(); i++) begin
      check("spacing", stamp_q[i] - stamp_q[i-1], DIV);
    end
    for (int i = 2; i < stamp_q.size(); i++) begin
      check("channel spacing", stamp_q[i] - stamp_q[i-2], 2 * DIV);
    end
    // Group mode: all four words are queued before the next sample clock, all four channels update together
    upd_q.delete();
    wr(8'h00, 32'h00000005);
    wr(8'h08, 32'h0000000F);
    for (int i = 0; i < 4; i++) push(16'(16'hB000 + i), 1'b0);
    settle(DIV + 20);
    check("group count", upd_q.size(), 1);
    check("group mask", upd_q[0].update, 4'hF);
    for (int c = 0; c < 4; c++) check("group value", upd_q[0].value[c], 16'hB000 + c);
    // Burst with software trigger as initiator
    wr(8'h00, 32'h00000006);
    wr(8'h08, 32'h00000001);
    wr(8'h04, 32'h00000007);
    push(16'hC000, 1'b0);
    push(16'hC001, 1'b1);
    push(16'hC002, 1'b1);
    upd_q.delete();
    trig_low_seen = 1'b0;
    settle(DIV + 20);
    check("untriggered", upd_q.size(), 0);
    wr(8'h04, 32'h0000000F);
    rd(8'h04, 32'h0000000F);
    rd(8'h0C, 32'h00000006);
    settle(2 * DIV + 20);
    check("burst count", upd_q.size(), 2);
    for (int i = 0; i < upd_q.size(); i++) upd_is(i, 0, 16'hC000 + i);
    check("trigger pulse", trig_low_seen, 1'b1);
    rd(8'h04, 32'h00000007);
    rd(8'h0C, 32'h00000003);
    // Rate generator as the only trigger source
    upd_q.delete();
    wr(8'h50, 32'h00000028);
    wr(8'h00, 32'h0000000E);
    settle(DIV + 60);
    check("rate trigger", upd_q.size(), 1);
    if (upd_q.size() > 0) upd_is(0, 0, 16'hC002);
    wr(8'h00, 32'h00000004);
    // A burst the rate generator started on the empty buffer must end before new data
    settle(DIV + 40);
    // Target: falling edge on the trigger pin, then a software trigger
    push(16'hD000, 1'b1);
    push(16'hD001, 1'b1);
    upd_q.delete();
    @(posedge clk) trig_drv <= 1'b0;
    settle(6);
    trig_drv <= 1'b1;
    settle(DIV + 20);
    check("pin burst", upd_q.size(), 1);
    if (upd_q.size() > 0) upd_is(0, 0, 16'hD000);
    wr(8'h04, 32'h0000000F);
    settle(DIV + 20);
    check("sw target burst", upd_q.size(), 2);
    if (upd_q.size() > 1) upd_is(1, 0, 16'hD001);
    // External clock as a clock target: nothing moves until the pin falls
    wr(8'h04, 32'h00000001);
    push(16'hE000, 1'b0);
    push(16'hE001, 1'b0);
    upd_q.delete();
    settle(20);
    check("no pin clock", upd_q.size(), 0);
    for (int i = 0; i < 2; i++) begin
      clk_drv <= 1'b0;
      settle(3);
      clk_drv <= 1'b1;
      settle(5);
    end
    settle(10);
    check("pin clock count", upd_q.size(), 2);
    for (int i = 0; i < upd_q.size(); i++) upd_is(i, 0, 16'hE000 + i);
    close_out();
  end
endmodule // tb_dac_output_clock_burst_sequencer
